/* File: src/ccm_pkg.sv */
// Purpose: constants for the converter measurement configuration bank
// Assumes: 8-bit registers, one per aligned Wishbone word, byte address = index * 4
// Notes: offsets are register indices
//
// Summary of operation
// - two 2-bit discharge resistor selectors: 180k, 90k, 30k default, 10k
// - discharge config bit 3 enables internal discharge resistors, default on
// - external discharge enable switches aux port in discharge, hi-z otherwise
// - aux bit 6: 0 keeps aux pull-down active, 1 disables it
// - aux bit 5 activates aux port only during internal reference conversion
// - bit 2 keeps on-chip discharge resistor permanently connected, default off
// - bit 1 keeps aux port permanently active
// - charge resistor select: 0 = 180k, 1 = 10k default
// - bit 7 selects external reference on port 0 or internal reference port
// - bit 4 activates on-chip parasitic and gain compensation
// - bit 1 selects single-ended or differential sensing
// - bit 0 selects grounded or floating sensors
// - alternating order reverses the order of ports 0-5 after every sequence; the internal reference port stays last
// - bit 3 clocks converter from low or high frequency oscillator
// - bit 2 quadruples cycle clock period, only with high-frequency source
// - bit 1 adds safety delay, bit 7 reduces clock path delays
// - dc balance drives both sides hi-z, only differential floating mode
// - 6-bit port enable, one bit per port; zero stops conversion
// - 13-bit averaging count over two registers; 0 and 1 mean one sample
// - 23-bit conversion time sets trigger period 2 * value low-freq clocks
// - discharge time value+1 cycles low-freq, value+0 high-freq; 1023 off
// - low-freq coarse tune selects 10, 50, 100 or 200 kHz
// - discharge time upper two bits sit in bits 1:0 of next register

package ccm_pkg;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [3:0] CCM_IDX_OSC_TUNE = 4'h0;
  localparam logic [3:0] CCM_IDX_DISCHG = 4'h2;
  localparam logic [3:0] CCM_IDX_AUX = 4'h3;
  localparam logic [3:0] CCM_IDX_SENSOR = 4'h4;
  localparam logic [3:0] CCM_IDX_CYCLE = 4'h5;
  localparam logic [3:0] CCM_IDX_PORT_EN = 4'h6;
  localparam logic [3:0] CCM_IDX_AVG_LO = 4'h7;
  localparam logic [3:0] CCM_IDX_AVG_HI = 4'h8;
  localparam logic [3:0] CCM_IDX_CONV_B0 = 4'h9;
  localparam logic [3:0] CCM_IDX_CONV_B1 = 4'ha;
  localparam logic [3:0] CCM_IDX_CONV_B2 = 4'hb;
  localparam logic [3:0] CCM_IDX_DTIME_LO = 4'hc;
  localparam logic [3:0] CCM_IDX_DTIME_HI = 4'hd;
  localparam int CCM_NUM_REGS = 14;
  // ---------------------------------------------------------------
  // reset values and writable bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] CCM_RST_DISCHG = 8'ha8;
  localparam logic [7:0] CCM_RST_AUX = 8'h01;
  localparam logic [7:0] CCM_RST_ZERO = 8'h00;
  localparam logic [7:0] CCM_MASK_OSC = 8'h03;
  localparam logic [7:0] CCM_MASK_DISCHG = 8'hfa;
  localparam logic [7:0] CCM_MASK_AUX = 8'h67;
  localparam logic [7:0] CCM_MASK_SENSOR = 8'hb3;
  localparam logic [7:0] CCM_MASK_CYCLE = 8'haf;
  localparam logic [7:0] CCM_MASK_PORT = 8'h3f;
  localparam logic [7:0] CCM_MASK_AVG_HI = 8'h1f;
  localparam logic [7:0] CCM_MASK_CONV_B2 = 8'h7f;
  localparam logic [7:0] CCM_MASK_DT_HI = 8'h03;
  localparam logic [7:0] CCM_MASK_FULL = 8'hff;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CCM_B_SEL_HI = 6;
  localparam int CCM_B_SEL_LO = 4;
  localparam int CCM_B_INT_EN = 3;
  localparam int CCM_B_EXT_EN = 1;
  localparam int CCM_B_PD_OFF = 6;
  localparam int CCM_B_AUX_REF = 5;
  localparam int CCM_B_INT_PERM = 2;
  localparam int CCM_B_AUX_PERM = 1;
  localparam int CCM_B_CHG_SEL = 0;
  localparam int CCM_B_REF_INT = 7;
  localparam int CCM_B_COMP_EXT = 5;
  localparam int CCM_B_COMP_INT = 4;
  localparam int CCM_B_DIFF = 1;
  localparam int CCM_B_FLOAT = 0;
  localparam int CCM_B_DLY_RED = 7;
  localparam int CCM_B_ALT = 5;
  localparam int CCM_B_HF_SEL = 3;
  localparam int CCM_B_QUAD = 2;
  localparam int CCM_B_SAFE = 1;
  localparam int CCM_B_DC_BAL = 0;
  // ---------------------------------------------------------------
  // counts
  // ---------------------------------------------------------------
  localparam logic [9:0] CCM_DTIME_OFF = 10'h3ff;
  localparam logic [2:0] CCM_INT_REF_PORT = 3'h6;
  localparam logic [2:0] CCM_NO_PORT = 3'h7;
  typedef enum logic [1:0] {
    CCM_IDLE = 2'b00,
    CCM_DISCHG = 2'b01,
    CCM_CHARGE = 2'b10
  } ccm_state_type;
endpackage

/* File: src/ccm_measure_cfg.sv */
// Purpose: configuration bank and measurement sequencer of the converter front end
// Assumes: classic Wishbone slave, 32-bit data, register byte in lane 0
// Notes: oscillators arrive as asynchronous pins and are filtered into ticks
`timescale 1ns/1ps
`default_nettype none

module ccm_measure_cfg #(
  parameter int CHARGE_CYCLES = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // oscillator pins
  input wire logic low_freq_osc_i,
  input wire logic high_freq_osc_i,
  // oscillator and clock path control
  output logic [1:0] lowfreq_coarse_tune_o,
  output logic cycle_clk_src_sel_o,
  output logic cycle_clk_quad_period_o,
  output logic clk_path_safety_delay_o,
  output logic clk_path_delay_reduce_o,
  // front end control
  output logic [1:0] dischg_res_code_o,
  output logic int_dischg_connect_o,
  output logic charge_res_sel_o,
  output logic ref_internal_o,
  output logic offchip_comp_o,
  output logic onchip_comp_o,
  output logic differential_o,
  output logic floating_o,
  output logic dc_free_drive_o,
  output logic aux_port_o,
  output logic aux_port_oe_o,
  output logic aux_pulldown_en_o,
  // measurement status
  output logic conv_busy_o,
  output logic dischg_phase_o,
  output logic charge_phase_o,
  output logic [2:0] active_port_o,
  output logic sample_done_o,
  output logic seq_done_o
);
  import ccm_pkg::*;
  if (CHARGE_CYCLES < 1 || CHARGE_CYCLES > 255) begin : g_chk
    $error("CHARGE_CYCLES must lie in 1..255");
  end

  // ---------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------
  function automatic logic [7:0] ccm_mask(input logic [3:0] idx);
    logic [7:0] m;
    m = CCM_MASK_FULL;
    if (idx == CCM_IDX_OSC_TUNE) m = CCM_MASK_OSC;
    else if (idx == CCM_IDX_DISCHG) m = CCM_MASK_DISCHG;
    else if (idx == CCM_IDX_AUX) m = CCM_MASK_AUX;
    else if (idx == CCM_IDX_SENSOR) m = CCM_MASK_SENSOR;
    else if (idx == CCM_IDX_CYCLE) m = CCM_MASK_CYCLE;
    else if (idx == CCM_IDX_PORT_EN) m = CCM_MASK_PORT;
    else if (idx == CCM_IDX_AVG_HI) m = CCM_MASK_AVG_HI;
    else if (idx == CCM_IDX_CONV_B2) m = CCM_MASK_CONV_B2;
    else if (idx == CCM_IDX_DTIME_HI) m = CCM_MASK_DT_HI;
    return m;
  endfunction

  logic [7:0] cfg_reg [CCM_NUM_REGS];
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] avg_wr_reg;
  logic [2:0] conv_wr_reg;
  logic [1:0] dt_wr_reg;
  logic [12:0] avg_act_reg;
  logic [22:0] conv_act_reg;
  logic [9:0] dt_act_reg;
  wire [3:0] idx = adr_i[5:2];
  wire mapped = (adr_i[7:6] == 2'b00) && (adr_i[1:0] == 2'b00) && (idx != 4'h1) && (idx <= CCM_IDX_DTIME_HI);
  wire req = cyc_i && stb_i && !ack_reg && !ack_o;
  wire wr_byte = req && we_i && sel_i[0] && mapped;
  wire [7:0] wr_val = dat_i[7:0] & ccm_mask(idx);
  wire [31:0] rd_val = mapped ? {24'h000000, cfg_reg[idx]} : 32'h00000000;

  // staged byte view used for commit of multi-byte fields
  wire [7:0] avg_lo_n = (wr_byte && idx == CCM_IDX_AVG_LO) ? wr_val : cfg_reg[CCM_IDX_AVG_LO];
  wire [7:0] avg_hi_n = (wr_byte && idx == CCM_IDX_AVG_HI) ? wr_val : cfg_reg[CCM_IDX_AVG_HI];
  wire [7:0] cv0_n = (wr_byte && idx == CCM_IDX_CONV_B0) ? wr_val : cfg_reg[CCM_IDX_CONV_B0];
  wire [7:0] cv1_n = (wr_byte && idx == CCM_IDX_CONV_B1) ? wr_val : cfg_reg[CCM_IDX_CONV_B1];
  wire [7:0] cv2_n = (wr_byte && idx == CCM_IDX_CONV_B2) ? wr_val : cfg_reg[CCM_IDX_CONV_B2];
  wire [7:0] dt_lo_n = (wr_byte && idx == CCM_IDX_DTIME_LO) ? wr_val : cfg_reg[CCM_IDX_DTIME_LO];
  wire [7:0] dt_hi_n = (wr_byte && idx == CCM_IDX_DTIME_HI) ? wr_val : cfg_reg[CCM_IDX_DTIME_HI];
  wire [1:0] avg_wr_next = avg_wr_reg | {wr_byte && idx == CCM_IDX_AVG_HI, wr_byte && idx == CCM_IDX_AVG_LO};
  wire [2:0] conv_wr_next = conv_wr_reg | {wr_byte && idx == CCM_IDX_CONV_B2,
                                           wr_byte && idx == CCM_IDX_CONV_B1,
                                           wr_byte && idx == CCM_IDX_CONV_B0};
  wire [1:0] dt_wr_next = dt_wr_reg | {wr_byte && idx == CCM_IDX_DTIME_HI, wr_byte && idx == CCM_IDX_DTIME_LO};
  genvar gi;
  generate
    for (gi = 0; gi < CCM_NUM_REGS; gi++) begin : g_reg
      localparam logic [7:0] RST = (gi == CCM_IDX_DISCHG) ? CCM_RST_DISCHG :
                                   (gi == CCM_IDX_AUX) ? CCM_RST_AUX : CCM_RST_ZERO;
      always_ff @(posedge clk_i) begin
        if (rst_i) cfg_reg[gi] <= RST;
        else if (wr_byte && idx == 4'(gi)) cfg_reg[gi] <= wr_val;
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= req;
      rdata_reg <= rd_val;
    end
  end

  // partial writes keep the running value; commit only when the whole field is new
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avg_wr_reg <= 2'b00;
      conv_wr_reg <= 3'b000;
      dt_wr_reg <= 2'b00;
      avg_act_reg <= 13'h0000;
      conv_act_reg <= 23'h000000;
      dt_act_reg <= 10'h000;
    end else begin
      avg_wr_reg <= (&avg_wr_next) ? 2'b00 : avg_wr_next;
      conv_wr_reg <= (&conv_wr_next) ? 3'b000 : conv_wr_next;
      dt_wr_reg <= (&dt_wr_next) ? 2'b00 : dt_wr_next;
      if (&avg_wr_next) avg_act_reg <= {avg_hi_n[4:0], avg_lo_n};
      if (&conv_wr_next) conv_act_reg <= {cv2_n[6:0], cv1_n, cv0_n};
      if (&dt_wr_next) dt_act_reg <= {dt_hi_n[1:0], dt_lo_n};
    end
  end

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  wire [7:0] r_dis = cfg_reg[CCM_IDX_DISCHG];
  wire [7:0] r_aux = cfg_reg[CCM_IDX_AUX];
  wire [7:0] r_sen = cfg_reg[CCM_IDX_SENSOR];
  wire [7:0] r_cyc = cfg_reg[CCM_IDX_CYCLE];
  wire [5:0] port_en = cfg_reg[CCM_IDX_PORT_EN][5:0];
  wire hf_sel = r_cyc[CCM_B_HF_SEL];
  wire ref_int = r_sen[CCM_B_REF_INT];
  wire [6:0] en7 = {ref_int, port_en};
  // ---------------------------------------------------------------
  // oscillator synchronisers and cycle clock
  // ---------------------------------------------------------------
  logic [1:0] osc_s1_reg, osc_s2_reg, osc_s3_reg, osc_lvl_reg;
  logic [1:0] quad_reg;
  wire [1:0] osc_pin = {high_freq_osc_i, low_freq_osc_i};
  wire [1:0] osc_rise;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_osc
      assign osc_rise[gi] = (osc_s2_reg[gi] == osc_s3_reg[gi]) && osc_s3_reg[gi] && !osc_lvl_reg[gi];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          osc_s1_reg[gi] <= 1'b0;
          osc_s2_reg[gi] <= 1'b0;
          osc_s3_reg[gi] <= 1'b0;
          osc_lvl_reg[gi] <= 1'b0;
        end else begin
          osc_s1_reg[gi] <= osc_pin[gi];
          osc_s2_reg[gi] <= osc_s1_reg[gi];
          osc_s3_reg[gi] <= osc_s2_reg[gi];
          if (osc_s2_reg[gi] == osc_s3_reg[gi]) osc_lvl_reg[gi] <= osc_s3_reg[gi];
        end
      end
    end
  endgenerate

  wire lf_tick = osc_rise[0];
  wire hf_tick = osc_rise[1];
  wire quad_on = hf_sel && r_cyc[CCM_B_QUAD];
  wire cyc_tick = hf_sel ? (hf_tick && (!quad_on || quad_reg == 2'b11)) : lf_tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) quad_reg <= 2'b00;
    else if (hf_tick) quad_reg <= quad_reg + 2'b01;
  end
  // ---------------------------------------------------------------
  // conversion trigger timer
  // ---------------------------------------------------------------
  logic [23:0] timer_reg;
  wire [23:0] period = {conv_act_reg, 1'b0};
  wire timer_hit = lf_tick && (conv_act_reg != 23'h000000) && (timer_reg + 24'h000001 >= period);
  always_ff @(posedge clk_i) begin
    if (rst_i) timer_reg <= 24'h000000;
    else if (timer_hit) timer_reg <= 24'h000000;
    else if (lf_tick) timer_reg <= timer_reg + 24'h000001;
  end

  // ---------------------------------------------------------------
  // measurement sequencer
  // ---------------------------------------------------------------
  function automatic logic [2:0] ccm_port(input logic [2:0] pos, input logic rev);
    logic [2:0] p;
    p = pos;
    if (rev && pos != CCM_INT_REF_PORT) p = 3'h5 - pos;
    return p;
  endfunction
  function automatic logic [2:0] ccm_next(input logic [2:0] from, input logic [6:0] en, input logic rev);
    logic [2:0] r;
    r = CCM_NO_PORT;
    for (int i = 6; i >= 0; i--) begin
      if (3'(i) >= from && en[ccm_port(3'(i), rev)]) r = 3'(i);
    end
    return r;
  endfunction

  ccm_state_type state_reg, state_next;
  logic [2:0] pos_reg;
  logic rev_reg;
  logic [12:0] smp_reg;
  logic [10:0] dcnt_reg;
  logic [7:0] ccnt_reg;
  logic smp_done_reg, seq_done_reg;
  wire [12:0] samples = (avg_act_reg <= 13'h0001) ? 13'h0001 : avg_act_reg;
  wire [10:0] dlen = hf_sel ? {1'b0, dt_act_reg} : {1'b0, dt_act_reg} + 11'h001;
  wire dis_skip = (dt_act_reg == CCM_DTIME_OFF) || (dlen == 11'h000);
  wire [2:0] first_pos = ccm_next(3'h0, en7, rev_reg);
  wire [2:0] next_pos = ccm_next(pos_reg + 3'h1, en7, rev_reg);
  wire start = (state_reg == CCM_IDLE) && timer_hit && (first_pos != CCM_NO_PORT) && (port_en != 6'h00);
  wire stop = (port_en == 6'h00) && (state_reg != CCM_IDLE);
  wire charge_end = (state_reg == CCM_CHARGE) && cyc_tick && (ccnt_reg == 8'h01);
  wire more_smp = (smp_reg + 13'h0001) < samples;
  wire seq_end = charge_end && !more_smp && (next_pos == CCM_NO_PORT);
  wire [2:0] cur_port = ccm_port(pos_reg, rev_reg);
  wire enter_dis = start || (charge_end && (more_smp || next_pos != CCM_NO_PORT));
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CCM_IDLE: begin
        if (start) state_next = dis_skip ? CCM_CHARGE : CCM_DISCHG;
      end
      CCM_DISCHG: begin
        if (cyc_tick && dcnt_reg == 11'h001) state_next = CCM_CHARGE;
      end
      CCM_CHARGE: begin
        if (seq_end) state_next = CCM_IDLE;
        else if (charge_end && !dis_skip) state_next = CCM_DISCHG;
      end
      default: state_next = CCM_IDLE;
    endcase
    if (stop) state_next = CCM_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= CCM_IDLE;
      pos_reg <= 3'h0;
      rev_reg <= 1'b0;
      smp_reg <= 13'h0000;
      dcnt_reg <= 11'h000;
      ccnt_reg <= 8'h00;
      smp_done_reg <= 1'b0;
      seq_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      smp_done_reg <= charge_end && !stop;
      seq_done_reg <= seq_end && !stop;
      if (start) pos_reg <= first_pos;
      else if (charge_end && !more_smp && next_pos != CCM_NO_PORT) pos_reg <= next_pos;
      if (start || (charge_end && !more_smp)) smp_reg <= 13'h0000;
      else if (charge_end) smp_reg <= smp_reg + 13'h0001;
      if (seq_end && r_cyc[CCM_B_ALT] && !stop) rev_reg <= !rev_reg;
      if (enter_dis) dcnt_reg <= dlen;
      else if (state_reg == CCM_DISCHG && cyc_tick) dcnt_reg <= dcnt_reg - 11'h001;
      if (enter_dis || (state_reg == CCM_DISCHG && state_next == CCM_CHARGE)) ccnt_reg <= 8'(CHARGE_CYCLES);
      else if (state_reg == CCM_CHARGE && cyc_tick) ccnt_reg <= ccnt_reg - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // front end drive
  // ---------------------------------------------------------------
  wire busy = state_reg != CCM_IDLE;
  wire dis_ph = state_reg == CCM_DISCHG;
  wire on_ref = busy && cur_port == CCM_INT_REF_PORT;
  wire hi_grp = cur_port == 3'h4 || cur_port == 3'h5;
  wire aux_oe_n = r_aux[CCM_B_AUX_PERM] ||
                  (r_aux[CCM_B_AUX_REF] ? on_ref :
                  (r_dis[CCM_B_EXT_EN] && dis_ph));
  wire int_con_n = r_dis[CCM_B_INT_EN] && (dis_ph || r_aux[CCM_B_INT_PERM]);
  wire [1:0] res_n = hi_grp ? r_dis[CCM_B_SEL_HI +: 2] : r_dis[CCM_B_SEL_LO +: 2];
  wire dcfree_n = r_cyc[CCM_B_DC_BAL] && r_sen[CCM_B_DIFF] && r_sen[CCM_B_FLOAT];

  // outputs lag their cause by one clock, ack, read data and done strobes by two; harmless next to oscillator periods
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      lowfreq_coarse_tune_o <= 2'b00;
      cycle_clk_src_sel_o <= 1'b0;
      cycle_clk_quad_period_o <= 1'b0;
      clk_path_safety_delay_o <= 1'b0;
      clk_path_delay_reduce_o <= 1'b0;
      dischg_res_code_o <= 2'b10;
      int_dischg_connect_o <= 1'b0;
      charge_res_sel_o <= 1'b1;
      ref_internal_o <= 1'b0;
      offchip_comp_o <= 1'b0;
      onchip_comp_o <= 1'b0;
      differential_o <= 1'b0;
      floating_o <= 1'b0;
      dc_free_drive_o <= 1'b0;
      aux_port_o <= 1'b0;
      aux_port_oe_o <= 1'b0;
      aux_pulldown_en_o <= 1'b1;
      conv_busy_o <= 1'b0;
      dischg_phase_o <= 1'b0;
      charge_phase_o <= 1'b0;
      active_port_o <= 3'h0;
      sample_done_o <= 1'b0;
      seq_done_o <= 1'b0;
    end else begin
      ack_o <= ack_reg;
      dat_o <= rdata_reg;
      lowfreq_coarse_tune_o <= cfg_reg[CCM_IDX_OSC_TUNE][1:0];
      cycle_clk_src_sel_o <= hf_sel;
      cycle_clk_quad_period_o <= quad_on;
      clk_path_safety_delay_o <= r_cyc[CCM_B_SAFE];
      clk_path_delay_reduce_o <= r_cyc[CCM_B_DLY_RED];
      dischg_res_code_o <= res_n;
      int_dischg_connect_o <= int_con_n;
      charge_res_sel_o <= r_aux[CCM_B_CHG_SEL];
      ref_internal_o <= ref_int;
      offchip_comp_o <= r_sen[CCM_B_COMP_EXT];
      onchip_comp_o <= r_sen[CCM_B_COMP_INT];
      differential_o <= r_sen[CCM_B_DIFF];
      floating_o <= r_sen[CCM_B_FLOAT];
      dc_free_drive_o <= dcfree_n;
      aux_port_o <= 1'b0;
      aux_port_oe_o <= aux_oe_n;
      aux_pulldown_en_o <= !r_aux[CCM_B_PD_OFF];
      conv_busy_o <= busy;
      dischg_phase_o <= dis_ph;
      charge_phase_o <= state_reg == CCM_CHARGE;
      active_port_o <= cur_port;
      sample_done_o <= smp_done_reg;
      seq_done_o <= seq_done_reg;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_req;
    cyc_i && stb_i && !ack_reg && !ack_o;
  endsequence
  sequence s_ack;
    ##2 ack_o ##1 !ack_o;
  endsequence

  bus_ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i) s_req |-> s_ack)
    else $error("ack not given two cycles after request");
  avg_commit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(avg_act_reg) |-> $past(wr_byte) && ($past(idx) == CCM_IDX_AVG_LO || $past(idx) == CCM_IDX_AVG_HI))
    else $error("average count changed without a write");
  dt_commit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(dt_act_reg) |-> $past(dt_wr_next) == 2'b11)
    else $error("discharge time committed early");
  port_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    port_en == 6'h00 |=> state_reg == CCM_IDLE ##1 !conv_busy_o)
    else $error("conversion ran with no port enabled");
  dis_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start && dis_skip |=> state_reg == CCM_CHARGE)
    else $error("discharge phase entered while switched off");
  aux_perm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r_aux[CCM_B_AUX_PERM] |-> ##1 aux_port_oe_o && !aux_port_o)
    else $error("aux port not held active");
  aux_ref_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r_aux[CCM_B_AUX_REF] && !r_aux[CCM_B_AUX_PERM] && !on_ref |-> ##1 !aux_port_oe_o)
    else $error("aux port active outside internal reference");
  dc_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(r_sen[CCM_B_DIFF] && r_sen[CCM_B_FLOAT]) |-> ##1 !dc_free_drive_o)
    else $error("dc balance outside differential floating mode");
  order_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_end && !stop && r_cyc[CCM_B_ALT] |=> rev_reg != $past(rev_reg))
    else $error("port order not reversed after sequence");
  quad_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !hf_sel |-> ##1 !cycle_clk_quad_period_o)
    else $error("quad period active with low-freq source");

endmodule

`default_nettype wire

/* File: bench/ccm_osc_model.sv */
// Purpose: oscillator pins that feed the measurement block
// Assumes: both oscillators run free, with no phase tie to the bus clock
// Notes: low frequency is scaled up so that runs stay short
`timescale 1ns/1ps
`default_nettype none
module ccm_osc_model #(
  parameter real LF_HALF = 20.0,
  parameter real HF_HALF = 10.0
) (
  // oscillator pins
  output logic low_freq_osc_o,
  output logic high_freq_osc_o
);
  initial low_freq_osc_o = 1'b0;
  initial high_freq_osc_o = 1'b0;
  always #(LF_HALF) low_freq_osc_o = ~low_freq_osc_o;
  always #(HF_HALF) high_freq_osc_o = ~high_freq_osc_o;
endmodule
`default_nettype wire

/* File: bench/tb_ccm_measure_cfg.sv */
// Purpose: register and sequencer checks of the measurement block
// Assumes: classic wishbone master, one request at a time
// Notes: waits are bounded; a hang ends in the closing report
`timescale 1ns/1ps
`default_nettype none
module tb_ccm_measure_cfg;
  import ccm_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic lf, hf, ack, quad, chg, aoe, apd, busy, dph, dcf, idc, cph, sd, qd, ap;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [1:0] rcode;
  wire [1:0] sen;
  wire [7:0] cfgo;
  logic [2:0] port;
  int errors = 0, total_checks = 0, cycles = 0, n;
  ccm_osc_model u_ccm_osc_model (.low_freq_osc_o(lf), .high_freq_osc_o(hf));
  ccm_measure_cfg #(.CHARGE_CYCLES(2)) u_ccm_measure_cfg (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .low_freq_osc_i(lf), .high_freq_osc_i(hf), .lowfreq_coarse_tune_o(cfgo[1:0]), .cycle_clk_src_sel_o(cfgo[2]),
    .cycle_clk_quad_period_o(quad), .clk_path_safety_delay_o(cfgo[3]), .clk_path_delay_reduce_o(cfgo[4]),
    .dischg_res_code_o(rcode), .int_dischg_connect_o(idc), .charge_res_sel_o(chg), .ref_internal_o(cfgo[5]),
    .offchip_comp_o(cfgo[6]), .onchip_comp_o(cfgo[7]), .differential_o(sen[1]), .floating_o(sen[0]),
    .dc_free_drive_o(dcf), .aux_port_o(ap), .aux_port_oe_o(aoe), .aux_pulldown_en_o(apd), .conv_busy_o(busy),
    .dischg_phase_o(dph), .charge_phase_o(cph), .active_port_o(port), .sample_done_o(sd), .seq_done_o(qd));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until ack is seen, then released for a cycle
  task wb(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {2'b00, i, 2'b00}; wdat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) errors++;
  endtask
  task rd(input logic [3:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic wt(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 2000) begin @(negedge clk_i); n++; end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CCM_IDX_DISCHG, CCM_RST_DISCHG);
    rd(CCM_IDX_AUX, CCM_RST_AUX);
    @(negedge clk_i);
    chk(32'(rcode), 32'h2);
    chk(32'(apd), 32'h1);
    chk(32'({cfgo, idc, ap}), 32'h0);
    $display("test reset done");
    wb(1'b1, CCM_IDX_SENSOR, 8'hff);
    rd(CCM_IDX_SENSOR, CCM_MASK_SENSOR);
    rd(4'h1, 8'h00);
    wb(1'b1, CCM_IDX_CYCLE, 8'h04);
    @(negedge clk_i);
    chk(32'(quad), 32'h0);
    wb(1'b1, CCM_IDX_OSC_TUNE, 8'h03);
    wb(1'b1, CCM_IDX_CYCLE, 8'h8f);
    @(negedge clk_i);
    chk(32'(quad), 32'h1);
    chk(32'(dcf), 32'h1);
    chk(32'(cfgo), 32'hff);
    chk(32'(sen), 32'h3);
    wb(1'b1, CCM_IDX_AUX, 8'h44);
    @(negedge clk_i);
    chk(32'(apd), 32'h0);
    chk(32'(chg), 32'h0);
    chk(32'(idc), 32'h1);
    $display("test config done");
    wb(1'b1, CCM_IDX_CYCLE, 8'h00);
    wb(1'b1, CCM_IDX_AUX, 8'h40);
    wb(1'b1, CCM_IDX_SENSOR, 8'h00);
    wb(1'b1, CCM_IDX_DISCHG, 8'haa);
    wb(1'b1, CCM_IDX_CONV_B0, 8'h02);
    wb(1'b1, CCM_IDX_CONV_B1, 8'h00);
    wb(1'b1, CCM_IDX_CONV_B2, 8'h00);
    wb(1'b1, CCM_IDX_PORT_EN, 8'h01);
    wt(busy);
    chk(32'(busy), 32'h1);
    chk(32'(port), 32'h0);
    wt(dph);
    chk(32'(aoe), 32'h1);
    chk(32'(idc), 32'h1);
    chk(32'(ap), 32'h0);
    wb(1'b1, CCM_IDX_PORT_EN, 8'h00);
    repeat (4) @(negedge clk_i);
    chk(32'({busy, idc}), 32'h0);
    $display("test measure done");
    wb(1'b1, CCM_IDX_CYCLE, 8'h20);
    wb(1'b1, CCM_IDX_AVG_LO, 8'h02);
    wb(1'b1, CCM_IDX_AVG_HI, 8'h00);
    wb(1'b1, CCM_IDX_DTIME_LO, 8'hff);
    wb(1'b1, CCM_IDX_DTIME_HI, 8'h03);
    rd(CCM_IDX_DTIME_HI, 8'h03);
    wb(1'b1, CCM_IDX_PORT_EN, 8'h01);
    wt(busy);
    chk(32'({busy, dph, cph, aoe}), 32'ha);
    wt(sd);
    chk(32'(sd), 32'h1);
    wt(qd);
    chk(32'(qd), 32'h1);
    $display("test skip done");
    final_report;
  end
endmodule
`default_nettype wire
